// ### rtl/ifr_readback.sv
// Infoframe bar, audio and change-flag readback bank
//
// Notes on behaviour
// - Flag bits 3..6 set on MPEG source, ACP, ISRC1, ISRC2 changes.
// - Second seven-bit flag register at 0x8F mirrors the primary flags.
// - Register 0x88 returns the top-bar end line upper byte, read-only.
// - Lower bar start line: low byte 0x89, high byte 0x8A, read-only.
// - Left bar last pixel: low 0x8B, high 0x8C; zero means none.
// - Right bar first pixel: low 0x8D, high 0x8E; too large means none.
// - Audio coding type sits in bits 7..4 of read-only register 0x91.
// - Coding 0 stream header, 1 linear PCM, 2 first multichannel format.
// - Reading any flag register zeroes every flag except those set by an event in that same cycle.
// - Flag bits 0..2 set on AVI, audio and SPD infoframe changes.
// - Top-bar end line low byte at 0x86; zero means no top bar.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ifr_readback (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [ifr_pkg::ADDR_W-1:0] I_S_AXI_AWADDR,
  input wire logic I_S_AXI_AWVALID,
  output logic O_S_AXI_AWREADY,
  input wire logic [ifr_pkg::DATA_W-1:0] I_S_AXI_WDATA,
  input wire logic [3:0] I_S_AXI_WSTRB,
  input wire logic I_S_AXI_WVALID,
  output logic O_S_AXI_WREADY,
  output logic [1:0] O_S_AXI_BRESP,
  output logic O_S_AXI_BVALID,
  input wire logic I_S_AXI_BREADY,
  input wire logic [ifr_pkg::ADDR_W-1:0] I_S_AXI_ARADDR,
  input wire logic I_S_AXI_ARVALID,
  output logic O_S_AXI_ARREADY,
  output logic [ifr_pkg::DATA_W-1:0] O_S_AXI_RDATA,
  output logic [1:0] O_S_AXI_RRESP,
  output logic O_S_AXI_RVALID,
  input wire logic I_S_AXI_RREADY,
  input wire logic [ifr_pkg::FLAG_W-1:0] I_PKT_CHANGE,
  input wire logic I_AVI_LOAD,
  input wire ifr_pkg::ifr_bars_s I_AVI_BARS,
  input wire logic I_AUD_LOAD,
  input wire ifr_pkg::ifr_audio_s I_AUD_INFO,
  output logic O_IRQ
);
  import ifr_pkg::*;

  logic wr_en;
  ifr_wreq_s wreq;
  logic wr_ok;
  logic rd_en;
  logic [IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;

  logic [FLAG_W-1:0] packet_change_flag_r;
  logic [FLAG_W-1:0] packet_change_flag_nxt;
  logic [FLAG_W-1:0] change_ev;
  logic flag_read;

  logic [FLAG_W-1:0] irq_stat_r;
  logic [FLAG_W-1:0] irq_mask_r;
  logic irq_r;
  logic stat_wr;
  logic mask_wr;

  logic [7:0] audio_frame_version_r;
  logic [3:0] audio_format_code_field_r;

  logic [7:0] top_lo;
  logic [7:0] top_hi;
  logic [7:0] bot_lo;
  logic [7:0] bot_hi;
  logic [7:0] left_lo;
  logic [7:0] left_hi;
  logic [7:0] right_lo;
  logic [7:0] right_hi;
  logic irq_pend;
  logic [FLAG_W-1:0] stat_clr;
  logic flag_idx;

  // Full bus words, so every read view is zero-padded to the bus width
  logic [DATA_W-1:0] word_top_lo;
  logic [DATA_W-1:0] word_top_hi;
  logic [DATA_W-1:0] word_bot_lo;
  logic [DATA_W-1:0] word_bot_hi;
  logic [DATA_W-1:0] word_left_lo;
  logic [DATA_W-1:0] word_left_hi;
  logic [DATA_W-1:0] word_right_lo;
  logic [DATA_W-1:0] word_right_hi;
  logic [DATA_W-1:0] word_flags;
  logic [DATA_W-1:0] word_flags_mir;
  logic [DATA_W-1:0] word_aud_ver;
  logic [DATA_W-1:0] word_aud_code;
  logic [DATA_W-1:0] word_irq_stat;
  logic [DATA_W-1:0] word_irq_mask;

  ifr_axil_slave u_bus (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_awaddr(I_S_AXI_AWADDR),
    .i_awvalid(I_S_AXI_AWVALID),
    .o_awready(O_S_AXI_AWREADY),
    .i_wdata(I_S_AXI_WDATA),
    .i_wstrb(I_S_AXI_WSTRB),
    .i_wvalid(I_S_AXI_WVALID),
    .o_wready(O_S_AXI_WREADY),
    .o_bresp(O_S_AXI_BRESP),
    .o_bvalid(O_S_AXI_BVALID),
    .i_bready(I_S_AXI_BREADY),
    .i_araddr(I_S_AXI_ARADDR),
    .i_arvalid(I_S_AXI_ARVALID),
    .o_arready(O_S_AXI_ARREADY),
    .o_rdata(O_S_AXI_RDATA),
    .o_rresp(O_S_AXI_RRESP),
    .o_rvalid(O_S_AXI_RVALID),
    .i_rready(I_S_AXI_RREADY),
    .o_wr_en(wr_en),
    .o_wreq(wreq),
    .i_wr_ok(wr_ok),
    .o_rd_en(rd_en),
    .o_rd_idx(rd_idx),
    .i_rd_data(rd_data),
    .i_rd_ok(rd_ok)
  );

  // Bar boundaries: one holder per value, all loaded from the same frame
  ifr_bar_hold #(.WIDTH(16)) u_top (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_load(I_AVI_LOAD),
    .i_value(I_AVI_BARS.top_end),
    .o_low(top_lo),
    .o_high(top_hi)
  );

  ifr_bar_hold #(.WIDTH(16)) u_bottom (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_load(I_AVI_LOAD),
    .i_value(I_AVI_BARS.bottom_start),
    .o_low(bot_lo),
    .o_high(bot_hi)
  );

  ifr_bar_hold #(.WIDTH(16)) u_left (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_load(I_AVI_LOAD),
    .i_value(I_AVI_BARS.left_end),
    .o_low(left_lo),
    .o_high(left_hi)
  );

  ifr_bar_hold #(.WIDTH(16)) u_right (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_load(I_AVI_LOAD),
    .i_value(I_AVI_BARS.right_start),
    .o_low(right_lo),
    .o_high(right_hi)
  );

  // Change events by packet kind
  always_comb begin
    change_ev = '0;
    change_ev[FLG_AVI] = I_PKT_CHANGE[FLG_AVI];
    change_ev[FLG_AUDIO] = I_PKT_CHANGE[FLG_AUDIO];
    change_ev[FLG_SPD] = I_PKT_CHANGE[FLG_SPD];
    change_ev[FLG_MPEG] = I_PKT_CHANGE[FLG_MPEG];
    change_ev[FLG_ACP] = I_PKT_CHANGE[FLG_ACP];
    change_ev[FLG_ISRC1] = I_PKT_CHANGE[FLG_ISRC1];
    change_ev[FLG_ISRC2] = I_PKT_CHANGE[FLG_ISRC2];
  end

  // Either flag view read clears the shared flags
  assign flag_idx = rd_idx == IDX_FLAGS || rd_idx == IDX_FLAGS_MIR;
  assign flag_read = rd_en && flag_idx;

  // Event in the clearing cycle survives the read-clear
  always_comb begin
    packet_change_flag_nxt = flag_read ? FLAGS_RST : packet_change_flag_r;
    packet_change_flag_nxt = packet_change_flag_nxt | change_ev;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      packet_change_flag_r <= FLAGS_RST;
    end else begin
      packet_change_flag_r <= packet_change_flag_nxt;
    end
  end

  // Audio infoframe fields; coding passes through as received
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      audio_frame_version_r <= BYTE_RST;
    end else if (I_AUD_LOAD) begin
      audio_frame_version_r <= I_AUD_INFO.version;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      audio_format_code_field_r <= ACT_STREAM;
    end else if (I_AUD_LOAD) begin
      audio_format_code_field_r <= I_AUD_INFO.coding;
    end
  end

  // Interrupt status and mask; writes use byte lane 0 only
  assign stat_wr = wr_en && wreq.idx == IDX_IRQ_STAT && wreq.strb[0];
  assign mask_wr = wr_en && wreq.idx == IDX_IRQ_MASK && wreq.strb[0];

  // Write-one-to-clear; an event in the same cycle still sets
  assign stat_clr = stat_wr ? wreq.data[FLAG_W-1:0] : FLAGS_RST;

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      irq_stat_r <= FLAGS_RST;
    end else begin
      irq_stat_r <= (irq_stat_r & ~stat_clr) | change_ev;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      irq_mask_r <= FLAGS_RST;
    end else if (mask_wr) begin
      irq_mask_r <= wreq.data[FLAG_W-1:0];
    end
  end

  assign irq_pend = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_pend;
    end
  end

  assign O_IRQ = irq_r;

  // Only the two interrupt registers accept writes; the rest refuse
  always_comb begin
    wr_ok = 1'b0;
    unique case (wreq.idx)
      IDX_IRQ_STAT, IDX_IRQ_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Narrow registers sit in the low bits; coding sits in its nibble
  assign word_top_lo = DATA_W'(top_lo);
  assign word_top_hi = DATA_W'(top_hi);
  assign word_bot_lo = DATA_W'(bot_lo);
  assign word_bot_hi = DATA_W'(bot_hi);
  assign word_left_lo = DATA_W'(left_lo);
  assign word_left_hi = DATA_W'(left_hi);
  assign word_right_lo = DATA_W'(right_lo);
  assign word_right_hi = DATA_W'(right_hi);

  assign word_flags = DATA_W'(packet_change_flag_r);
  assign word_flags_mir = DATA_W'(packet_change_flag_r);
  assign word_aud_ver = DATA_W'(audio_frame_version_r);
  assign word_aud_code =
    DATA_W'(audio_format_code_field_r) << AUD_CODE_LSB;

  assign word_irq_stat = DATA_W'(irq_stat_r);
  assign word_irq_mask = DATA_W'(irq_mask_r);

  // Mapped indices answer OKAY; any other index is refused
  always_comb begin
    rd_ok = 1'b0;
    unique case (rd_idx)
      IDX_TOP_LO, IDX_FLAGS, IDX_TOP_HI, IDX_BOT_LO, IDX_BOT_HI,
      IDX_LEFT_LO, IDX_LEFT_HI, IDX_RIGHT_LO, IDX_RIGHT_HI,
      IDX_FLAGS_MIR, IDX_AUD_VER, IDX_AUD_CODE, IDX_IRQ_STAT,
      IDX_IRQ_MASK: rd_ok = 1'b1;
      default: rd_ok = 1'b0;
    endcase
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    rd_data = WORD_ZERO;
    unique case (rd_idx)
      IDX_TOP_LO: rd_data = word_top_lo;
      IDX_FLAGS: rd_data = word_flags;
      IDX_TOP_HI: rd_data = word_top_hi;
      IDX_BOT_LO: rd_data = word_bot_lo;
      IDX_BOT_HI: rd_data = word_bot_hi;
      IDX_LEFT_LO: rd_data = word_left_lo;
      IDX_LEFT_HI: rd_data = word_left_hi;
      IDX_RIGHT_LO: rd_data = word_right_lo;
      IDX_RIGHT_HI: rd_data = word_right_hi;
      IDX_FLAGS_MIR: rd_data = word_flags_mir;
      IDX_AUD_VER: rd_data = word_aud_ver;
      IDX_AUD_CODE: rd_data = word_aud_code;
      IDX_IRQ_STAT: rd_data = word_irq_stat;
      IDX_IRQ_MASK: rd_data = word_irq_mask;
      default: rd_data = WORD_ZERO;
    endcase
  end
endmodule // ifr_readback

// ### rtl/ifr_pkg.sv
// Shared constants and carriers of the infoframe readback bank
package ifr_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam int FLAG_W = 7;
  localparam int IDX_LSB = 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TOP_LO = 8'h86;
  localparam logic [IDX_W-1:0] IDX_FLAGS = 8'h87;
  localparam logic [IDX_W-1:0] IDX_TOP_HI = 8'h88;
  localparam logic [IDX_W-1:0] IDX_BOT_LO = 8'h89;
  localparam logic [IDX_W-1:0] IDX_BOT_HI = 8'h8A;
  localparam logic [IDX_W-1:0] IDX_LEFT_LO = 8'h8B;
  localparam logic [IDX_W-1:0] IDX_LEFT_HI = 8'h8C;
  localparam logic [IDX_W-1:0] IDX_RIGHT_LO = 8'h8D;
  localparam logic [IDX_W-1:0] IDX_RIGHT_HI = 8'h8E;
  localparam logic [IDX_W-1:0] IDX_FLAGS_MIR = 8'h8F;
  localparam logic [IDX_W-1:0] IDX_AUD_VER = 8'h90;
  localparam logic [IDX_W-1:0] IDX_AUD_CODE = 8'h91;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'hA0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'hA1;

  // Change flag bit positions
  localparam int FLG_AVI = 0;
  localparam int FLG_AUDIO = 1;
  localparam int FLG_SPD = 2;
  localparam int FLG_MPEG = 3;
  localparam int FLG_ACP = 4;
  localparam int FLG_ISRC1 = 5;
  localparam int FLG_ISRC2 = 6;

  localparam int AUD_CODE_LSB = 4;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 7'h00;
  localparam logic [15:0] BAR_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ACT_STREAM = 4'h0,
    ACT_PCM = 4'h1,
    ACT_MC_FIRST = 4'h2
  } ifr_coding_e;

  typedef struct packed {
    logic [15:0] top_end;
    logic [15:0] bottom_start;
    logic [15:0] left_end;
    logic [15:0] right_start;
  } ifr_bars_s;

  typedef struct packed {
    logic [7:0] version;
    logic [3:0] coding;
  } ifr_audio_s;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] data;
    logic [3:0] strb;
  } ifr_wreq_s;
endpackage

// ### rtl/ifr_bar_hold.sv
// One 16-bit bar boundary holder, split into two byte views
`timescale 1ns/1ps
module ifr_bar_hold #(
  parameter int WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_value,
  output logic [7:0] o_low,
  output logic [7:0] o_high
);
  import ifr_pkg::*;
  logic [WIDTH-1:0] value_r;

  // Both halves load on the same strobe so a read never mixes frames
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      value_r <= '0;
    end else if (i_load) begin
      value_r <= i_value;
    end
  end

  assign o_low = value_r[7:0];
  assign o_high = value_r[15:8];
endmodule // ifr_bar_hold

// ### rtl/ifr_axil_slave.sv
// AXI4-Lite slave front end: handshakes, strobes and responses
`timescale 1ns/1ps
module ifr_axil_slave (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [ifr_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ifr_pkg::DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ifr_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [ifr_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_wr_en,
  output ifr_pkg::ifr_wreq_s o_wreq,
  input wire logic i_wr_ok,
  output logic o_rd_en,
  output logic [ifr_pkg::IDX_W-1:0] o_rd_idx,
  input wire logic [ifr_pkg::DATA_W-1:0] i_rd_data,
  input wire logic i_rd_ok
);
  import ifr_pkg::*;
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_hs;
  logic w_hs;
  logic aw_have;
  logic w_have;
  logic [ADDR_W-1:0] aw_eff;

  assign o_awready = !aw_held_r && !bvalid_r;
  assign o_wready = !w_held_r && !bvalid_r;
  assign aw_hs = i_awvalid && o_awready;
  assign w_hs = i_wvalid && o_wready;
  assign aw_have = aw_held_r || aw_hs;
  assign w_have = w_held_r || w_hs;
  assign aw_eff = aw_held_r ? awaddr_r : i_awaddr;

  // Write fires once both halves are in, in either order
  assign o_wr_en = aw_have && w_have && !bvalid_r;
  always_comb begin
    o_wreq.idx = aw_eff[IDX_LSB +: IDX_W];
    o_wreq.data = w_held_r ? wdata_r : i_wdata;
    o_wreq.strb = w_held_r ? wstrb_r : i_wstrb;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= WORD_ZERO;
      wstrb_r <= 4'h0;
    end else begin
      if (aw_hs) begin
        awaddr_r <= i_awaddr;
      end
      if (w_hs) begin
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end
      aw_held_r <= aw_have && !o_wr_en;
      w_held_r <= w_have && !o_wr_en;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (o_wr_en) begin
      bvalid_r <= 1'b1;
      bresp_r <= i_wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;

  // One read outstanding; address taken only when no data is waiting
  assign o_arready = !rvalid_r;
  assign o_rd_en = i_arvalid && o_arready;
  assign o_rd_idx = i_araddr[IDX_LSB +: IDX_W];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= WORD_ZERO;
      rresp_r <= RESP_OKAY;
    end else if (o_rd_en) begin
      rvalid_r <= 1'b1;
      rdata_r <= i_rd_data;
      rresp_r <= i_rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
endmodule // ifr_axil_slave

// ### bench/ifr_src_model.sv
// Infoframe source model feeding the packet side of the bank
`timescale 1ns/1ps
module ifr_src_model (
  input wire logic i_clk,
  output logic [6:0] o_chg = '0,
  output logic o_avi = 1'b0,
  output ifr_pkg::ifr_bars_s o_bars = '0,
  output logic o_aud = 1'b0,
  output ifr_pkg::ifr_audio_s o_info = '0
);
  import ifr_pkg::*;
  task send_chg(input logic [6:0] m);
    @(posedge i_clk);
    o_chg <= m;
    @(posedge i_clk);
    o_chg <= '0;
  endtask
  // Payload inverted outside its load cycle so stale data cannot match
  task send_bars(input ifr_bars_s v);
    @(posedge i_clk);
    o_bars <= v;
    o_avi <= 1'b1;
    @(posedge i_clk);
    o_bars <= ~v;
    o_avi <= 1'b0;
  endtask
  task send_aud(input ifr_audio_s v);
    @(posedge i_clk);
    o_info <= v;
    o_aud <= 1'b1;
    @(posedge i_clk);
    o_info <= ~v;
    o_aud <= 1'b0;
  endtask
endmodule // ifr_src_model

// ### bench/ifr_checker_assertions.sv
// Concurrent checks on the readback bank top-level ports
`timescale 1ns/1ps
module ifr_checker (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [1:0] O_S_AXI_BRESP,
  input wire logic O_S_AXI_BVALID,
  input wire logic I_S_AXI_BREADY,
  input wire logic [ifr_pkg::ADDR_W-1:0] I_S_AXI_ARADDR,
  input wire logic I_S_AXI_ARVALID,
  input wire logic O_S_AXI_ARREADY,
  input wire logic [ifr_pkg::DATA_W-1:0] O_S_AXI_RDATA,
  input wire logic [1:0] O_S_AXI_RRESP,
  input wire logic O_S_AXI_RVALID,
  input wire logic I_S_AXI_RREADY,
  input wire logic [ifr_pkg::FLAG_W-1:0] I_PKT_CHANGE,
  input wire logic I_AUD_LOAD,
  input wire ifr_pkg::ifr_audio_s I_AUD_INFO,
  input wire logic O_IRQ
);
  import ifr_pkg::*;
  logic [IDX_W-1:0] idx;
  logic go;
  logic clr;
  logic [FLAG_W-1:0] flg_r;
  logic [FLAG_W-1:0] flg_nxt;
  logic [3:0] code_r;
  assign idx = I_S_AXI_ARADDR[9:2];
  assign go = I_S_AXI_ARVALID && O_S_AXI_ARREADY;
  assign clr = go && (idx == IDX_FLAGS || idx == IDX_FLAGS_MIR);
  // An event in the clearing cycle survives the clear
  assign flg_nxt = (clr ? FLAGS_RST : flg_r) | I_PKT_CHANGE;
  always_ff @(posedge I_CLOCK) begin
    flg_r <= I_RST ? FLAGS_RST : flg_nxt;
  end
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      code_r <= 4'h0;
    end else if (I_AUD_LOAD) begin
      code_r <= I_AUD_INFO.coding;
    end
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  property p_flag_rd;
    clr |=> O_S_AXI_RDATA == DATA_W'($past(flg_r));
  endproperty
  a_flag_rd: assert property (p_flag_rd)
    else $error("flag read wrong");
  property p_code_rd;
    go && idx == IDX_AUD_CODE |=> O_S_AXI_RDATA[7:4] == $past(code_r);
  endproperty
  a_code_rd: assert property (p_code_rd)
    else $error("coding field wrong");
  property p_unmap;
    go && idx == 8'h00 |=> O_S_AXI_RRESP == RESP_SLVERR
      && O_S_AXI_RDATA == WORD_ZERO;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read answered wrongly");
  property p_r_ans; go |=> O_S_AXI_RVALID; endproperty
  a_r_ans: assert property (p_r_ans)
    else $error("read not answered next cycle");
  property p_r_hold;
    O_S_AXI_RVALID && !I_S_AXI_RREADY |=> O_S_AXI_RVALID
      && $stable(O_S_AXI_RDATA) && $stable(O_S_AXI_RRESP);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped");
  property p_ar_blk; O_S_AXI_RVALID |-> !O_S_AXI_ARREADY; endproperty
  a_ar_blk: assert property (p_ar_blk)
    else $error("address taken during answer");
  property p_b_hold;
    O_S_AXI_BVALID && !I_S_AXI_BREADY |=> O_S_AXI_BVALID
      && $stable(O_S_AXI_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped");
  property p_rst;
    disable iff (1'b0) I_RST |=> !O_S_AXI_BVALID && !O_S_AXI_RVALID
      && !O_IRQ;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs active after reset");
  c_clr: cover property (clr && O_S_AXI_RDATA != WORD_ZERO);
  c_irq: cover property ($rose(O_IRQ));
  c_err: cover property (O_S_AXI_BVALID && O_S_AXI_BRESP == RESP_SLVERR);
endmodule // ifr_checker

bind ifr_readback ifr_checker i_chk (.I_CLOCK, .I_RST, .O_S_AXI_BRESP,
  .O_S_AXI_BVALID, .I_S_AXI_BREADY, .I_S_AXI_ARADDR, .I_S_AXI_ARVALID,
  .O_S_AXI_ARREADY, .O_S_AXI_RDATA, .O_S_AXI_RRESP, .O_S_AXI_RVALID,
  .I_S_AXI_RREADY, .I_PKT_CHANGE, .I_AUD_LOAD, .I_AUD_INFO, .O_IRQ);

// ### bench/tb.sv
// Self-checking bench of the infoframe readback bank
`timescale 1ns/1ps
`define CHK(a, e) chk(32'(a), 32'(e))
module tb;
  import ifr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] awa = '0, ara = '0;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [31:0] wd = '0, seed = 32'h0000_F4FE, d;
  logic [1:0] r;
  logic [13:0] m;
  wire awr, wrd, bv, arr, rv, irq, al, ul;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [6:0] chg;
  wire ifr_bars_s bars;
  wire ifr_audio_s info;
  ifr_bars_s b;
  ifr_audio_s u;
  int fails = 0, cmp_count = 0;
  logic [7:0] lo [4] = '{IDX_TOP_LO, IDX_BOT_LO, IDX_LEFT_LO, IDX_RIGHT_LO};
  logic [7:0] hi [4] = '{IDX_TOP_HI, IDX_BOT_HI, IDX_LEFT_HI, IDX_RIGHT_HI};
  always #50 clk = ~clk;
  ifr_readback i_dut (.I_CLOCK(clk), .I_RST(rst), .I_S_AXI_AWADDR(awa),
    .I_S_AXI_AWVALID(awv), .O_S_AXI_AWREADY(awr), .I_S_AXI_WDATA(wd),
    .I_S_AXI_WSTRB(4'hF), .I_S_AXI_WVALID(wv), .O_S_AXI_WREADY(wrd),
    .O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bv), .I_S_AXI_BREADY(br),
    .I_S_AXI_ARADDR(ara), .I_S_AXI_ARVALID(arv), .O_S_AXI_ARREADY(arr),
    .O_S_AXI_RDATA(rdata), .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rv),
    .I_S_AXI_RREADY(rr), .I_PKT_CHANGE(chg), .I_AVI_LOAD(al),
    .I_AVI_BARS(bars), .I_AUD_LOAD(ul), .I_AUD_INFO(info), .O_IRQ(irq));
  ifr_src_model i_src (.i_clk(clk), .o_chg(chg), .o_avi(al),
    .o_bars(bars), .o_aud(ul), .o_info(info));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [15:0] bar(ifr_bars_s v, int k);
    return v[63-16*k -: 16];
  endfunction
  task chk(input logic [31:0] a, e);
    cmp_count++;
    if (a !== e) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, a, e);
    end
  endtask
  task summarize();
    $display("Compared %0d, mismatched %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task lim(input int n);
    if (n >= 50) begin
      fails++;
      summarize();
    end
  endtask
  task rd(input logic [7:0] i);
    int n;
    n = 0;
    @(posedge clk);
    ara <= {i, 2'b00};
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (arr !== 1'b1 && n < 50);
    arv <= 1'b0;
    while (rv !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    d = rdata;
    r = rresp;
    rr <= 1'b0;
    lim(n);
  endtask
  task wr(input logic [7:0] i, input logic [31:0] v);
    int n;
    logic a, w;
    n = 0;
    a = 1'b1;
    w = 1'b1;
    @(posedge clk);
    awa <= {i, 2'b00};
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while ((a || w) && n < 50) begin
      @(posedge clk);
      n++;
      if (awr === 1'b1) a = 1'b0;
      if (wrd === 1'b1) w = 1'b0;
      awv <= a;
      wv <= w;
    end
    while (bv !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    r = bresp;
    br <= 1'b0;
    lim(n);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 5; n++) begin
      b = {rnd(), rnd()};
      // Empty top and left bars, bottom and right beyond any raster
      if (n == 4) b = 64'h0000_FFFF_0000_FFFF;
      i_src.send_bars(b);
      for (int k = 0; k < 4; k++) begin
        rd(lo[k]);
        `CHK(d, bar(b, k) & 16'h00FF);
        rd(hi[k]);
        `CHK(d, bar(b, k) >> 8);
      end
    end
    for (int c = 0; c < 4; c++) begin
      d = rnd();
      u = {d[7:0], (c == 3) ? d[11:8] : 4'(c)};
      i_src.send_aud(u);
      rd(IDX_AUD_VER);
      `CHK(d, u.version);
      rd(IDX_AUD_CODE);
      `CHK(d[7:4], u.coding);
    end
    for (int k = 0; k < 7; k++) begin
      i_src.send_chg(7'(1 << k));
      rd((k % 2) ? IDX_FLAGS_MIR : IDX_FLAGS);
      `CHK(d, 1 << k);
      rd((k % 2) ? IDX_FLAGS : IDX_FLAGS_MIR);
      `CHK(d, 0);
    end
    m = 14'(rnd());
    i_src.send_chg(m[6:0]);
    i_src.send_chg(m[13:7]);
    rd(IDX_FLAGS_MIR);
    `CHK(d, m[6:0] | m[13:7]);
    wr(IDX_TOP_HI, rnd());
    `CHK(r, RESP_SLVERR);
    rd(IDX_TOP_HI);
    `CHK(d, bar(b, 0) >> 8);
    rd(8'h00);
    `CHK(r, RESP_SLVERR);
    `CHK(d, 0);
    // Flag scenarios left every status bit set; start the mask test clean
    wr(IDX_IRQ_STAT, 32'h0000_007F);
    `CHK(r, RESP_OKAY);
    wr(IDX_IRQ_MASK, 32'h0000_007F);
    `CHK(r, RESP_OKAY);
    repeat (3) @(posedge clk);
    `CHK(irq, 0);
    i_src.send_chg(7'h10);
    repeat (3) @(posedge clk);
    `CHK(irq, 1);
    wr(IDX_IRQ_STAT, 32'h0000_0010);
    repeat (3) @(posedge clk);
    `CHK(irq, 0);
    wr(IDX_IRQ_MASK, 32'h0000_0000);
    i_src.send_chg(7'h7F);
    repeat (3) @(posedge clk);
    `CHK(irq, 0);
    rd(IDX_IRQ_STAT);
    `CHK(d, 32'h0000_007F);
    summarize();
  end
endmodule // tb
